// ---- tb/rpi_host_model.sv ----
// Purpose: Display controller model driving the pixel pins
// Assumes: Pixel clock period 125 ns
// Notes:   Clock stands still low between calls
`timescale 1ns/10ps
module rpi_host_model (
	output logic        pixel_clock,    // Pixel clock
	output logic        frame_sync_n,   // Frame sync, active low
	output logic        line_sync_n,    // Line sync, active low
	output logic        data_enable,    // Data enable
	output logic [17:0] pixel_data_pins // Pixel data
);
	initial begin
		pixel_clock = 1'b0;
		frame_sync_n = 1'b1;
		line_sync_n = 1'b1;
		data_enable = 1'b0;
		pixel_data_pins = 18'h0_0000;
	end
	// One dot, set up while the clock is low
	task automatic dot(input logic [17:0] d, input logic de);
		pixel_data_pins = d;
		data_enable = de;
		#31.25;
		pixel_clock = 1'b1;
		#62.5;
		pixel_clock = 1'b0;
		#31.25;
		data_enable = 1'b0;
		pixel_data_pins = {~d[17:12], d[11:0]};
	endtask
	// Sync pulse of one pixel clock, clock kept running
	task automatic sync(input logic frame);
		if (frame) frame_sync_n = 1'b0;
		else line_sync_n = 1'b0;
		dot(pixel_data_pins, 1'b0);
		frame_sync_n = 1'b1;
		line_sync_n = 1'b1;
		repeat (2) dot(pixel_data_pins, 1'b0);
	endtask
endmodule // rpi_host_model

// ---- tb/rpi_port_assertions.sv ----
// Purpose: Port-level checks of the pixel input port
// Assumes: ce held high, pixel clock far slower than sys_clk
// Notes:   Bound to every rpi_port instance
`timescale 1ns/10ps
module rpi_port_assertions (
	input wire logic        sys_clk,             // System clock
	input wire logic        rst,                 // Synchronous reset
	input wire logic        reg_re,              // Read strobe
	input wire logic [31:0] reg_rdata,           // Read data
	input wire logic        pixel_clock,         // Pixel clock pin
	input wire logic        frame_sync_n,        // Frame sync pin
	input wire logic        data_enable,         // Data enable pin
	input wire logic        gram_we,             // RAM write pulse
	input wire logic        ext_timing,          // Port timing active
	input wire logic        sysif_features_en,   // System features allowed
	input wire logic        line_pulse,          // Line pulse
	input wire logic        gate_nonoverlap,     // Non-overlap active
	input wire logic        source_output_delay, // Source delay active
	input wire logic        equalization_period, // Equalisation active
	input wire logic        front_porch          // Front porch
);
	logic [3:0] de_age_r;
	logic [3:0] pc_age_r;
	logic       pc_q_r;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Cycles since enable was last high and since the last raw clock rise
	always_ff @(posedge sys_clk) begin
		pc_q_r <= pixel_clock;
		if (rst || data_enable) de_age_r <= rst ? 4'hF : 4'h0;
		else if (de_age_r != 4'hF) de_age_r <= de_age_r + 4'h1;
		if (rst || (pixel_clock && !pc_q_r)) pc_age_r <= rst ? 4'hF : 4'h0;
		else if (pc_age_r != 4'hF) pc_age_r <= pc_age_r + 4'h1;
	end
	chk_we_single_pulse: assert property (gram_we |=> !gram_we)
		else $error("RAM write longer than one cycle");
	chk_we_port_on: assert property (gram_we |-> ext_timing)
		else $error("RAM write while port inactive");
	chk_we_needs_enable: assert property (gram_we |-> de_age_r < 4'h8)
		else $error("RAM write without data enable");
	chk_we_after_edge: assert property (gram_we |-> pc_age_r < 4'h8)
		else $error("RAM write without pixel clock rise");
	chk_features_excl: assert property (ext_timing != sysif_features_en)
		else $error("System features allowed while port active");
	chk_periods_port: assert property ((gate_nonoverlap || source_output_delay
		|| equalization_period) |-> ext_timing)
		else $error("Drive period active without pixel timing");
	chk_line_pulse_once: assert property (line_pulse |-> ext_timing ##1 !line_pulse)
		else $error("Line pulse malformed");
	chk_porch_hold: assert property ((front_porch && frame_sync_n && ext_timing) [*4]
		|=> front_porch || !ext_timing)
		else $error("Front porch left without frame sync");
	chk_porch_exit: assert property ($fell(frame_sync_n) && front_porch && ext_timing
		|-> ##[1:8] !front_porch)
		else $error("Front porch kept after frame sync");
	chk_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0000_0000)
		else $error("Read data outside read cycle");
endmodule // rpi_port_assertions

bind rpi_port rpi_port_assertions rpi_port_assertions_i (
	.sys_clk(sys_clk), .rst(rst), .reg_re(reg_re), .reg_rdata(reg_rdata),
	.pixel_clock(pixel_clock), .frame_sync_n(frame_sync_n), .data_enable(data_enable),
	.gram_we(gram_we), .ext_timing(ext_timing), .sysif_features_en(sysif_features_en),
	.line_pulse(line_pulse), .gate_nonoverlap(gate_nonoverlap),
	.source_output_delay(source_output_delay), .equalization_period(equalization_period),
	.front_porch(front_porch));

// ---- tb/rpi_port_tb.sv ----
// Purpose: Self-checking bench of the pixel input port
// Assumes: ce high except in the freeze scenario
// Notes:   Writes captured into queues and compared per dot
`timescale 1ns/10ps
module rpi_port_tb;
	logic        sys_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_we;
	logic        reg_re;
	logic [31:0] reg_rdata;
	logic        pixel_clock, frame_sync_n, line_sync_n, data_enable;
	logic [17:0] pixel_data_pins;
	logic        gram_we, ext_timing, sysif_features_en, line_pulse, front_porch;
	logic        ce, gate_nonoverlap, source_output_delay, equalization_period;
	logic [16:0] gram_addr;
	logic [17:0] gram_wdata;
	logic [16:0] qa[$];
	logic [17:0] qd[$];
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          lines = 0;

	rpi_port rpi_port_i (.sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.pixel_clock(pixel_clock), .frame_sync_n(frame_sync_n), .line_sync_n(line_sync_n),
		.data_enable(data_enable), .pixel_data_pins(pixel_data_pins), .gram_we(gram_we),
		.gram_addr(gram_addr), .gram_wdata(gram_wdata), .ext_timing(ext_timing),
		.sysif_features_en(sysif_features_en), .line_pulse(line_pulse),
		.gate_nonoverlap(gate_nonoverlap), .source_output_delay(source_output_delay),
		.equalization_period(equalization_period),
		.front_porch(front_porch));
	rpi_host_model rpi_host_model_i (.pixel_clock(pixel_clock), .frame_sync_n(frame_sync_n),
		.line_sync_n(line_sync_n), .data_enable(data_enable),
		.pixel_data_pins(pixel_data_pins));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (gram_we === 1'b1) begin
			qa.push_back(gram_addr);
			qd.push_back(gram_wdata);
		end
		if (line_pulse === 1'b1) lines++;
		if (cycles == 20000) begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge sys_clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1;
		chk(reg_rdata & m, e);
	endtask
	// One dot; we says whether a RAM write of w at a must follow
	task automatic px(input logic [17:0] d, input logic de, input logic we,
		input logic [16:0] a, input logic [17:0] w);
		rpi_host_model_i.dot(d, de);
		repeat (2) @(posedge sys_clk);
		chk(32'(qa.size()), {31'h0, we});
		if (qa.size() > 0) begin
			chk({15'h0, qa.pop_front()}, we ? {15'h0, a} : 32'hFFFF_FFFF);
			chk({14'h0, qd.pop_front()}, {14'h0, w});
		end
	endtask

	task automatic t_reset();
		rd(rpi_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(rpi_pkg::REG_WIN_H, 32'hFFFF_FFFF, 32'h00FF_0000);
		rd(rpi_pkg::REG_WIN_V, 32'hFFFF_FFFF, 32'h01FF_0000);
		rd(rpi_pkg::REG_PORCH, 32'hFFFF_FFFF, 32'h01FF_0202);
		rd(rpi_pkg::REG_PERIODS, 32'hFFFF_FFFF, 32'h0001_0101);
		chk({30'h0, ext_timing, sysif_features_en}, 32'h0000_0001);
	endtask
	task automatic t_full();
		wr(rpi_pkg::REG_WIN_H, 32'h0002_0001);
		wr(rpi_pkg::REG_WIN_V, 32'h0001_0000);
		wr(rpi_pkg::REG_ADDR_SET, 32'h0000_0001);
		wr(rpi_pkg::REG_PERIODS, 32'h0003_0200);
		wr(rpi_pkg::REG_CTRL, 32'h0000_000C);
		repeat (3) @(posedge sys_clk);
		chk({30'h0, ext_timing, sysif_features_en}, 32'h0000_0002);
		chk({29'h0, gate_nonoverlap, source_output_delay, equalization_period}, 32'h0000_0003);
		rpi_host_model_i.sync(1'b1);
		px(18'h1_2345, 1'b1, 1'b1, 17'h0_0001, 18'h1_2345);
		px(18'h2_0F0F, 1'b0, 1'b0, 17'h0_0000, 18'h0_0000);
		px(18'h2_0F0F, 1'b1, 1'b1, 17'h0_0002, 18'h2_0F0F);
		px(18'h3_FFFF, 1'b1, 1'b1, 17'h0_0101, 18'h3_FFFF);
		wr(rpi_pkg::REG_ADDR_SET, 32'h0000_0000);
		rpi_host_model_i.sync(1'b1);
		px(18'h0_0007, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
		px(18'h0_0009, 1'b1, 1'b1, 17'h0_0001, 18'h0_0009);
	endtask
	// Clock enable low must freeze capture and register writes
	task automatic t_freeze();
		@(posedge sys_clk);
		ce <= 1'b0;
		px(18'h1_1111, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
		wr(rpi_pkg::REG_CTRL, 32'h0000_0000);
		ce <= 1'b1;
		rd(rpi_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_000C);
	endtask
	task automatic t_porch();
		wr(rpi_pkg::REG_PORCH, 32'h0001_0201);
		lines = 0;
		rpi_host_model_i.sync(1'b1);
		chk({31'h0, front_porch}, 32'h0000_0000);
		repeat (4) rpi_host_model_i.sync(1'b0);
		chk({31'h0, front_porch}, 32'h0000_0001);
		chk({31'h0, lines != 0}, 32'h0000_0001);
		chk({29'h0, gate_nonoverlap, source_output_delay, equalization_period}, 32'h0000_0000);
		repeat (40) @(posedge sys_clk);
		chk({31'h0, front_porch}, 32'h0000_0001);
		rpi_host_model_i.sync(1'b1);
		chk({31'h0, front_porch}, 32'h0000_0000);
	endtask
	task automatic t_six();
		wr(rpi_pkg::REG_ADDR_SET, 32'h0000_0001);
		wr(rpi_pkg::REG_CTRL, 32'h0000_000E);
		for (int f = 0; f < 2; f++) begin
			rpi_host_model_i.sync(1'b1);
			px(18'h2_A000, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
			px(18'h1_5000, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
			px(18'h3_3000, 1'b1, 1'b1, 17'h0_0001, {6'h2A, 6'h15, 6'h33});
			if (f == 0) px(18'h2_A000, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
		end
		rd(rpi_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(rpi_pkg::REG_STATUS, 32'h0000_0001);
		rd(rpi_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic t_modes();
		logic [17:0] d;
		d = 18'h2_5A5C;
		wr(rpi_pkg::REG_CTRL, 32'h0000_000D);
		rpi_host_model_i.sync(1'b1);
		px(d, 1'b1, 1'b1, 17'h0_0001, {d[17:13], d[17], d[11:6], d[5:1], d[5]});
		wr(rpi_pkg::REG_CTRL, 32'h0000_000F);
		px(d, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
		rd(rpi_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0004);
		wr(rpi_pkg::REG_CTRL, 32'h0000_0008);
		px(d, 1'b1, 1'b0, 17'h0_0000, 18'h0_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(rpi_pkg::REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
		@(posedge sys_clk);
		wr(rpi_pkg::REG_CTRL, 32'h0000_000C);
		rpi_host_model_i.sync(1'b1);
		px(d, 1'b1, 1'b1, 17'h0_0001, d);
		wr(rpi_pkg::REG_CTRL, 32'h0000_0000);
		repeat (3) @(posedge sys_clk);
		chk({30'h0, ext_timing, sysif_features_en}, 32'h0000_0001);
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_we = 1'b0;
		reg_re = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_full();
		t_freeze();
		t_porch();
		t_six();
		t_modes();
		final_report();
	end
endmodule // rpi_port_tb

// ---- verilog/rpi_pkg.sv ----
// Purpose: Shared constants and types for the parallel RGB pixel input port
// Assumes: 8-bit register index, 32-bit register data, one word per register
// Notes:   Offsets are byte addresses on the plain register port
package rpi_pkg;
	// Register offsets
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_WIN_H     = 8'h04;
	localparam logic [7:0]  REG_WIN_V     = 8'h08;
	localparam logic [7:0]  REG_ADDR_SET  = 8'h0C;
	localparam logic [7:0]  REG_PORCH     = 8'h10;
	localparam logic [7:0]  REG_PERIODS   = 8'h14;
	localparam logic [7:0]  REG_STATUS    = 8'h18;
	localparam logic [7:0]  REG_ADDR_CNT  = 8'h1C;

	// Field positions
	localparam int CTRL_WIDTH_LSB   = 0;
	localparam int CTRL_RAM_PATH    = 2;
	localparam int CTRL_PORT_EN     = 3;
	localparam int WIN_START_LSB    = 0;
	localparam int WIN_END_LSB      = 16;
	localparam int SET_H_LSB        = 0;
	localparam int SET_V_LSB        = 8;
	localparam int PORCH_BP_LSB     = 0;
	localparam int PORCH_FP_LSB     = 8;
	localparam int PORCH_NL_LSB     = 16;
	localparam int PER_NOV_LSB      = 0;
	localparam int PER_STD_LSB      = 8;
	localparam int PER_EQ_LSB       = 16;
	localparam int STAT_FRAME_ERR   = 0;

	// Bus width codes
	localparam logic [1:0]  BUS_18        = 2'h0;
	localparam logic [1:0]  BUS_16        = 2'h1;
	localparam logic [1:0]  BUS_6         = 2'h2;
	localparam logic [1:0]  BUS_BAD       = 2'h3;

	// Dot phases in 6-bit mode
	localparam logic [1:0]  PH_FIRST      = 2'h0;
	localparam logic [1:0]  PH_SECOND     = 2'h1;
	localparam logic [1:0]  PH_THIRD      = 2'h2;

	// Reset values and dot count limit
	localparam logic [7:0]  RST_H_START   = 8'h00;
	localparam logic [7:0]  RST_H_END     = 8'hFF;
	localparam logic [8:0]  RST_V_START   = 9'h000;
	localparam logic [8:0]  RST_V_END     = 9'h1FF;
	localparam logic [3:0]  RST_BP        = 4'h2;
	localparam logic [3:0]  RST_FP        = 4'h2;
	localparam logic [8:0]  RST_NL        = 9'h1FF;
	localparam logic [1:0]  RST_PERIOD    = 2'h1;
	localparam logic [2:0]  DOT_CNT_MAX   = 3'h7;

	// Synchroniser lanes
	localparam int SYNC_W    = 22;
	localparam int PIN_PCLK  = 0;
	localparam int PIN_VS    = 1;
	localparam int PIN_HS    = 2;
	localparam int PIN_DE    = 3;
	localparam int PIN_DATA  = 4;

	typedef enum logic [1:0] {
		FS_IDLE,
		FS_BACK,
		FS_DISP,
		FS_FRONT
	} rpi_fstate_type;
endpackage

// ---- verilog/rpi_port.sv ----
// Purpose: Parallel RGB pixel input port writing pixels into graphics RAM
// Assumes: Pins sampled by sys_clk; pixel_clock much slower than sys_clk
// Notes:   Frame and line syncs active low, data enable active high
`timescale 1ns/10ps
module rpi_port (
	input  wire logic        sys_clk,              // System clock, 100 MHz
	input  wire logic        rst,                  // Synchronous reset, active high
	input  wire logic        ce,                   // Clock enable, freezes state when low
	input  wire logic [7:0]  reg_addr,             // Register byte address
	input  wire logic [31:0] reg_wdata,            // Register write data
	input  wire logic        reg_we,               // Register write strobe
	input  wire logic        reg_re,               // Register read strobe
	output logic      [31:0] reg_rdata,            // Read data, cycle after strobe
	input  wire logic        pixel_clock,          // Pixel clock pin
	input  wire logic        frame_sync_n,         // Frame sync pin, active low
	input  wire logic        line_sync_n,          // Line sync pin, active low
	input  wire logic        data_enable,          // Data enable pin, active high
	input  wire logic [17:0] pixel_data_pins,      // Pixel data pins
	output logic             gram_we,              // Graphics RAM write pulse
	output logic      [16:0] gram_addr,            // Graphics RAM address {v,h}
	output logic      [17:0] gram_wdata,           // Graphics RAM write word
	output logic             ext_timing,           // Display timed from pixel port
	output logic             sysif_features_en,    // Partial/scroll/interlace allowed
	output logic             line_pulse,           // Pulse per displayed line
	output logic             gate_nonoverlap,      // Gate non-overlap period active
	output logic             source_output_delay,  // Source output delay active
	output logic             equalization_period,  // Equalisation period active
	output logic             front_porch           // In front porch
);
	typedef struct packed {
		logic [1:0]             width;
		logic                   ram_path_select;
		logic                   port_en;
		logic [7:0]             h_start;
		logic [7:0]             h_end;
		logic [8:0]             v_start;
		logic [8:0]             v_end;
		logic [7:0]             set_h;
		logic [8:0]             set_v;
		logic [3:0]             bp;
		logic [3:0]             fp;
		logic [8:0]             nl;
		logic [1:0]             nov;
		logic [1:0]             std;
		logic [1:0]             eq;
		logic [1:0]             phase;
		logic [5:0]             red;
		logic [5:0]             green;
		logic [7:0]             cnt_h;
		logic [8:0]             cnt_v;
		rpi_pkg::rpi_fstate_type fstate;
		logic [8:0]             line_cnt;
		logic [2:0]             dot_cnt;
		logic                   frame_err;
		logic [31:0]            rdata;
		logic                   gram_we;
		logic [16:0]            gram_addr;
		logic [17:0]            gram_wdata;
		logic                   ext_timing;
		logic                   sys_feat;
		logic                   line_pulse;
		logic                   gate_nov;
		logic                   src_dly;
		logic                   eq_on;
		logic                   in_fp;
	} rpi_state_type;

	rpi_state_type                st_r;
	rpi_state_type                st_nxt;
	logic [rpi_pkg::SYNC_W-1:0]   pin_lvl;
	logic [rpi_pkg::SYNC_W-1:0]   pin_prev;
	logic                         dot_edge;
	logic                         vs_fall;
	logic                         hs_fall;
	logic [17:0]                  dat;
	logic                         take_dot;
	logic                         commit;
	logic [17:0]                  word;

	// Expand a dot or pixel from the pins into an 18-bit RAM word
	function automatic logic [17:0] map_word(input logic [1:0]  w,
	                                         input logic [17:0] d,
	                                         input logic [5:0]  r,
	                                         input logic [5:0]  g);
		logic [17:0] res;
		res = d;
		case (w)
			rpi_pkg::BUS_16: res = {d[17:13], d[17], d[11:6], d[5:1], d[5]};
			rpi_pkg::BUS_6:  res = {r, g, d[17:12]};
			default:         res = d;
		endcase
		return res;
	endfunction

	function automatic logic in_window(input rpi_state_type s);
		return (s.cnt_h >= s.h_start) && (s.cnt_h <= s.h_end) &&
		       (s.cnt_v >= s.v_start) && (s.cnt_v <= s.v_end);
	endfunction

	rpi_sync u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.ce      (ce),
		.pins_in ({pixel_data_pins, data_enable, line_sync_n, frame_sync_n, pixel_clock}),
		.lvl     (pin_lvl),
		.prev    (pin_prev)
	);

	assign dot_edge = pin_lvl[rpi_pkg::PIN_PCLK] & ~pin_prev[rpi_pkg::PIN_PCLK];
	assign vs_fall  = ~pin_lvl[rpi_pkg::PIN_VS] & pin_prev[rpi_pkg::PIN_VS];
	assign hs_fall  = ~pin_lvl[rpi_pkg::PIN_HS] & pin_prev[rpi_pkg::PIN_HS];
	assign dat      = pin_lvl[rpi_pkg::PIN_DATA +: 18];
	// Pixel bus only feeds RAM, gated by enable, path select and a legal width
	assign take_dot = dot_edge & pin_lvl[rpi_pkg::PIN_DE] & st_r.port_en &
	                  st_r.ram_path_select & (st_r.width != rpi_pkg::BUS_BAD);
	assign commit   = take_dot & ((st_r.width != rpi_pkg::BUS_6) |
	                  (st_r.phase == rpi_pkg::PH_THIRD));
	assign word     = map_word(st_r.width, dat, st_r.red, st_r.green);

	always_comb begin
		st_nxt = st_r;
		if (ce) begin
			st_nxt.gram_we    = 1'b0;
			st_nxt.line_pulse = 1'b0;
			st_nxt.rdata      = 32'h0000_0000;

			// Register writes come only from the system side port
			if (reg_we) begin
				case (reg_addr)
					rpi_pkg::REG_CTRL: begin
						st_nxt.width           = reg_wdata[rpi_pkg::CTRL_WIDTH_LSB +: 2];
						st_nxt.ram_path_select = reg_wdata[rpi_pkg::CTRL_RAM_PATH];
						st_nxt.port_en         = reg_wdata[rpi_pkg::CTRL_PORT_EN];
					end
					rpi_pkg::REG_WIN_H: begin
						st_nxt.h_start = reg_wdata[rpi_pkg::WIN_START_LSB +: 8];
						st_nxt.h_end   = reg_wdata[rpi_pkg::WIN_END_LSB +: 8];
					end
					rpi_pkg::REG_WIN_V: begin
						st_nxt.v_start = reg_wdata[rpi_pkg::WIN_START_LSB +: 9];
						st_nxt.v_end   = reg_wdata[rpi_pkg::WIN_END_LSB +: 9];
					end
					rpi_pkg::REG_ADDR_SET: begin
						st_nxt.set_h = reg_wdata[rpi_pkg::SET_H_LSB +: 8];
						st_nxt.set_v = reg_wdata[rpi_pkg::SET_V_LSB +: 9];
					end
					rpi_pkg::REG_PORCH: begin
						st_nxt.bp = reg_wdata[rpi_pkg::PORCH_BP_LSB +: 4];
						st_nxt.fp = reg_wdata[rpi_pkg::PORCH_FP_LSB +: 4];
						st_nxt.nl = reg_wdata[rpi_pkg::PORCH_NL_LSB +: 9];
					end
					rpi_pkg::REG_PERIODS: begin
						st_nxt.nov = reg_wdata[rpi_pkg::PER_NOV_LSB +: 2];
						st_nxt.std = reg_wdata[rpi_pkg::PER_STD_LSB +: 2];
						st_nxt.eq  = reg_wdata[rpi_pkg::PER_EQ_LSB +: 2];
					end
					rpi_pkg::REG_STATUS: begin
						if (reg_wdata[rpi_pkg::STAT_FRAME_ERR]) begin
							st_nxt.frame_err = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end

			if (reg_re) begin
				case (reg_addr)
					rpi_pkg::REG_CTRL:     st_nxt.rdata = {28'h000_0000, st_r.port_en,
					                                       st_r.ram_path_select, st_r.width};
					rpi_pkg::REG_WIN_H:    st_nxt.rdata = {8'h00, st_r.h_end, 8'h00, st_r.h_start};
					rpi_pkg::REG_WIN_V:    st_nxt.rdata = {7'h00, st_r.v_end, 7'h00, st_r.v_start};
					rpi_pkg::REG_ADDR_SET: st_nxt.rdata = {15'h0000, st_r.set_v, st_r.set_h};
					rpi_pkg::REG_PORCH:    st_nxt.rdata = {7'h00, st_r.nl, 4'h0, st_r.fp,
					                                       4'h0, st_r.bp};
					rpi_pkg::REG_PERIODS:  st_nxt.rdata = {14'h0000, st_r.eq, 6'h00, st_r.std,
					                                       6'h00, st_r.nov};
					rpi_pkg::REG_STATUS:   st_nxt.rdata = {24'h00_0000, st_r.fstate, st_r.phase,
					                                       st_r.in_fp,
					                                       st_r.width == rpi_pkg::BUS_BAD,
					                                       1'b0, st_r.frame_err};
					rpi_pkg::REG_ADDR_CNT: st_nxt.rdata = {15'h0000, st_r.cnt_v, st_r.cnt_h};
					default:               st_nxt.rdata = 32'h0000_0000;
				endcase
			end

			// Dot capture and pixel assembly
			if (take_dot && st_r.width == rpi_pkg::BUS_6) begin
				case (st_r.phase)
					rpi_pkg::PH_FIRST: begin
						st_nxt.red   = dat[17:12];
						st_nxt.phase = rpi_pkg::PH_SECOND;
					end
					rpi_pkg::PH_SECOND: begin
						st_nxt.green = dat[17:12];
						st_nxt.phase = rpi_pkg::PH_THIRD;
					end
					default: begin
						st_nxt.phase = rpi_pkg::PH_FIRST;
					end
				endcase
			end

			if (commit) begin
				// Counter walks the window; words outside it are dropped
				st_nxt.gram_we    = in_window(st_r);
				st_nxt.gram_addr  = {st_r.cnt_v, st_r.cnt_h};
				st_nxt.gram_wdata = word;
				if (st_r.cnt_h >= st_r.h_end) begin
					st_nxt.cnt_h = st_r.h_start;
					st_nxt.cnt_v = (st_r.cnt_v >= st_r.v_end) ? st_r.v_start :
					               9'(st_r.cnt_v + 9'h001);
				end else begin
					st_nxt.cnt_h = 8'(st_r.cnt_h + 8'h01);
				end
			end

			// Per-line periods counted in pixel clocks
			if (hs_fall) begin
				st_nxt.dot_cnt = 3'h0;
			end else if (dot_edge && st_r.dot_cnt != rpi_pkg::DOT_CNT_MAX) begin
				st_nxt.dot_cnt = 3'(st_r.dot_cnt + 3'h1);
			end

			// Vertical timing from external syncs
			case (st_r.fstate)
				rpi_pkg::FS_BACK: begin
					if (hs_fall) begin
						if (9'(st_r.line_cnt + 9'h001) >= {5'h00, st_r.bp}) begin
							st_nxt.fstate   = rpi_pkg::FS_DISP;
							st_nxt.line_cnt = 9'h000;
						end else begin
							st_nxt.line_cnt = 9'(st_r.line_cnt + 9'h001);
						end
					end
				end
				rpi_pkg::FS_DISP: begin
					if (hs_fall) begin
						st_nxt.line_pulse = 1'b1;
						if (9'(st_r.line_cnt + 9'h001) >= st_r.nl) begin
							st_nxt.fstate   = rpi_pkg::FS_FRONT;
							st_nxt.line_cnt = 9'h000;
						end else begin
							st_nxt.line_cnt = 9'(st_r.line_cnt + 9'h001);
						end
					end
				end
				rpi_pkg::FS_FRONT: begin
					// Front porch lasts until the next frame sync however long
					if (hs_fall && st_r.line_cnt != 9'h1FF) begin
						st_nxt.line_cnt = 9'(st_r.line_cnt + 9'h001);
					end
				end
				default: begin
				end
			endcase

			// Frame start overrides everything on the frame path
			if (vs_fall && st_r.port_en) begin
				st_nxt.cnt_h    = st_r.set_h;
				st_nxt.cnt_v    = st_r.set_v;
				st_nxt.phase    = rpi_pkg::PH_FIRST;
				st_nxt.line_cnt = 9'h000;
				st_nxt.fstate   = (st_r.bp == 4'h0) ? rpi_pkg::FS_DISP : rpi_pkg::FS_BACK;
				if (st_r.width == rpi_pkg::BUS_6 && st_r.phase != rpi_pkg::PH_FIRST) begin
					st_nxt.frame_err = 1'b1;
				end
			end
			if (!st_r.port_en) begin
				st_nxt.fstate = rpi_pkg::FS_IDLE;
			end

			st_nxt.ext_timing = st_nxt.port_en;
			st_nxt.sys_feat   = ~st_nxt.port_en;
			st_nxt.in_fp      = st_nxt.fstate == rpi_pkg::FS_FRONT;
			st_nxt.gate_nov   = st_nxt.port_en && (st_nxt.dot_cnt < {1'b0, st_nxt.nov});
			st_nxt.src_dly    = st_nxt.port_en && (st_nxt.dot_cnt < {1'b0, st_nxt.std});
			st_nxt.eq_on      = st_nxt.port_en && (st_nxt.dot_cnt < {1'b0, st_nxt.eq});
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r          <= '0;
			st_r.h_start  <= rpi_pkg::RST_H_START;
			st_r.h_end    <= rpi_pkg::RST_H_END;
			st_r.v_start  <= rpi_pkg::RST_V_START;
			st_r.v_end    <= rpi_pkg::RST_V_END;
			st_r.bp       <= rpi_pkg::RST_BP;
			st_r.fp       <= rpi_pkg::RST_FP;
			st_r.nl       <= rpi_pkg::RST_NL;
			st_r.nov      <= rpi_pkg::RST_PERIOD;
			st_r.std      <= rpi_pkg::RST_PERIOD;
			st_r.eq       <= rpi_pkg::RST_PERIOD;
			st_r.fstate   <= rpi_pkg::FS_IDLE;
			st_r.sys_feat <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata           = st_r.rdata;
	assign gram_we             = st_r.gram_we;
	assign gram_addr           = st_r.gram_addr;
	assign gram_wdata          = st_r.gram_wdata;
	assign ext_timing          = st_r.ext_timing;
	assign sysif_features_en   = st_r.sys_feat;
	assign line_pulse          = st_r.line_pulse;
	assign gate_nonoverlap     = st_r.gate_nov;
	assign source_output_delay = st_r.src_dly;
	assign equalization_period = st_r.eq_on;
	assign front_porch         = st_r.in_fp;
endmodule // rpi_port

// ---- verilog/rpi_sync.sv ----
// Purpose: Two-flop synchroniser for all pixel-port pins, plus one delay stage
// Assumes: Pins are asynchronous to sys_clk
// Notes:   Only the second and third stages leave this module
`timescale 1ns/10ps
module rpi_sync (
	input  wire logic                       sys_clk,  // System clock
	input  wire logic                       rst,      // Synchronous reset
	input  wire logic                       ce,       // Clock enable
	input  wire logic [rpi_pkg::SYNC_W-1:0] pins_in,  // Raw pins
	output logic      [rpi_pkg::SYNC_W-1:0] lvl,      // Synchronised level
	output logic      [rpi_pkg::SYNC_W-1:0] prev      // Level one cycle older
);
	typedef struct packed {
		logic [rpi_pkg::SYNC_W-1:0] s1;
		logic [rpi_pkg::SYNC_W-1:0] s2;
		logic [rpi_pkg::SYNC_W-1:0] s3;
	} rpi_sync_type;

	rpi_sync_type sync_r;
	rpi_sync_type sync_nxt;

	always_comb begin
		sync_nxt = sync_r;
		if (ce) begin
			sync_nxt.s1 = pins_in;
			sync_nxt.s2 = sync_r.s1;
			sync_nxt.s3 = sync_r.s2;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_r <= '0;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign lvl  = sync_r.s2;
	assign prev = sync_r.s3;
endmodule // rpi_sync
